// ===== verilog/a8tc_top.sv
// Top of the 8-bit timer control block: register bank, counter, compare and pin logic.
// Assumes a one-cycle register port and pin direction bits from the port logic on CLK.
`timescale 1ns/1ps
module a8tc_top
	import a8tc_pkg::*;
#(
	parameter int PRESCALE_W = 10
)(
	input  wire logic       CLK,
	input  wire logic       RSTN,
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WSTROBE,
	input  wire logic       RSTROBE,
	output logic      [7:0] RDATA,
	input  wire logic       TIMER_OSC_PIN_ONE,
	input  wire logic       ALTERNATE_CLOCK_PIN,
	input  wire logic       DIR_A,
	input  wire logic       DIR_B,
	input  wire logic       PORT_DATA_A,
	input  wire logic       PORT_DATA_B,
	output logic            COMPARE_PIN_A_OUT,
	output logic            COMPARE_PIN_A_OE_N,
	output logic            COMPARE_PIN_B_OUT,
	output logic            COMPARE_PIN_B_OE_N,
	output logic            COMPARE_A_MATCH,
	output logic            COMPARE_B_MATCH,
	output logic            XTAL_OSC_EN,
	output logic            EXT_CLK_BUF_EN,
	output logic            ALT_PIN_EN
);

	// Busy bit order inside the busy vector.
	localparam int B_CTB = 0;
	localparam int B_CTA = 1;
	localparam int B_OCB = 2;
	localparam int B_OCA = 3;
	localparam int B_CNT = 4;

	a8tc_clk_if clk_bus ();

	a8tc_prescaler #(
		.PRESCALE_W (PRESCALE_W)
	) u_prescaler (
		.clk     (CLK),
		.rst_n   (RSTN),
		.osc_pin (TIMER_OSC_PIN_ONE),
		.alt_pin (ALTERNATE_CLOCK_PIN),
		.clk_if  (clk_bus.core)
	);

	logic [7:0]      ctla_r, ctla_nxt;
	logic [7:0]      ctlb_r, ctlb_nxt;
	logic [7:0]      count_r, count_nxt;
	logic [7:0]      cmpa_r, cmpa_nxt;
	logic [7:0]      cmpb_r, cmpb_nxt;
	logic [7:0]      asr_r, asr_nxt;
	logic [7:0]      tmp_r [5];
	logic [7:0]      tmp_nxt [5];
	logic [4:0]      busy_r, busy_nxt;
	logic            block_r, block_nxt;
	a8tc_dir_t       dir_r, dir_nxt;
	logic            wave_a_r, wave_a_nxt;
	logic            wave_b_r, wave_b_nxt;
	logic            hit_a_r, hit_a_nxt;
	logic            hit_b_r, hit_b_nxt;
	logic [7:0]      rdata_r, rdata_nxt;
	logic [4:0]      wr;
	logic [4:0]      app;
	logic [7:0]      app_val [5];
	a8tc_wave_mode_t wmode;
	a8tc_out_mode_t  mode_a;
	a8tc_out_mode_t  mode_b;
	logic [7:0]      top;
	logic            tick;
	logic            match_a;
	logic            match_b;
	logic            frc_a;
	logic            frc_b;
	logic            async_sel;

	// PWM modes are the ones whose low waveform bit is set.
	function automatic logic is_pwm(input a8tc_wave_mode_t m);
		is_pwm = (m == WM_PC_FF) || (m == WM_FAST_FF) || (m == WM_PC_OCA) || (m == WM_FAST_OCA);
	endfunction : is_pwm

	// Pin level after a match for one channel in non-PWM modes.
	function automatic logic wave_step(input a8tc_out_mode_t m, input logic cur);
		case (m)
			OM_TOGGLE: wave_step = ~cur;
			OM_CLEAR:  wave_step = 1'b0;
			OM_SET:    wave_step = 1'b1;
			default:   wave_step = cur;
		endcase
	endfunction : wave_step

	// Decode of the live configuration shared by counter, compare and prescaler.
	assign async_sel            = asr_r[A8TC_ASEL];
	assign wmode                = a8tc_wave_mode_t'({ctlb_r[A8TC_WGM2], ctla_r[A8TC_WGM_LO +: 2]});
	assign mode_a               = a8tc_out_mode_t'(ctla_r[A8TC_COMA_LO +: 2]);
	assign mode_b               = a8tc_out_mode_t'(ctla_r[A8TC_COMB_LO +: 2]);
	assign clk_bus.async_sel    = async_sel;
	assign clk_bus.ext_clk      = asr_r[A8TC_EXT];
	assign clk_bus.alt_clk      = asr_r[A8TC_ALT];
	assign clk_bus.clock_select = ctlb_r[A8TC_CS_LO +: 3];
	assign tick                 = clk_bus.cnt_tick;

	// All register, counter and waveform next values in one place, so the priorities are visible.
	always_comb begin
		wr[B_CTA] = WSTROBE && (ADDR == A8TC_CTRL_A_OFS);
		wr[B_CTB] = WSTROBE && (ADDR == A8TC_CTRL_B_OFS);
		wr[B_CNT] = WSTROBE && (ADDR == A8TC_COUNT_OFS);
		wr[B_OCA] = WSTROBE && (ADDR == A8TC_CMP_A_OFS);
		wr[B_OCB] = WSTROBE && (ADDR == A8TC_CMP_B_OFS);
		tmp_nxt   = tmp_r;
		busy_nxt  = busy_r;
		for (int i = 0; i < 5; i++) begin
			// A synchronous write lands at once; an asynchronous one waits for a source tick.
			app[i]     = async_sel ? (busy_r[i] && clk_bus.src_tick && !wr[i]) : wr[i];
			app_val[i] = async_sel ? tmp_r[i] : WDATA;
			if (app[i]) begin
				busy_nxt[i] = 1'b0;
			end
			// A new write wins over a transfer in the same cycle; the flag stays set.
			if (wr[i] && async_sel) begin
				tmp_nxt[i]  = WDATA;
				busy_nxt[i] = 1'b1;
			end
		end
		asr_nxt = asr_r;
		if (WSTROBE && (ADDR == A8TC_ASYNC_OFS)) begin
			asr_nxt = WDATA & A8TC_ASYNC_MASK;
			// Pending transfers are dropped on a select change; software must rewrite the registers.
			if (WDATA[A8TC_ASEL] != async_sel) begin
				busy_nxt = 5'h00;
			end
		end
		ctla_nxt = app[B_CTA] ? (app_val[B_CTA] & A8TC_CTLA_MASK) : ctla_r;
		ctlb_nxt = app[B_CTB] ? (app_val[B_CTB] & A8TC_CTLB_MASK) : ctlb_r;
		cmpa_nxt = app[B_OCA] ? app_val[B_OCA] : cmpa_r;
		cmpb_nxt = app[B_OCB] ? app_val[B_OCB] : cmpb_r;
		// Force strobes act when control B is applied, only outside PWM modes.
		frc_a = app[B_CTB] && app_val[B_CTB][A8TC_FOCA] && !is_pwm(wmode);
		frc_b = app[B_CTB] && app_val[B_CTB][A8TC_FOCB] && !is_pwm(wmode);
		// Compare on every tick, blocked on the tick after a counter write.
		match_a = tick && (count_r == cmpa_r) && !block_r;
		match_b = tick && (count_r == cmpb_r) && !block_r;
		hit_a_nxt = match_a;
		hit_b_nxt = match_b;
		top = ((wmode == WM_CTC) || (wmode == WM_PC_OCA) || (wmode == WM_FAST_OCA)) ? cmpa_r : A8TC_TOP_MAX;
		count_nxt = count_r;
		dir_nxt   = dir_r;
		block_nxt = tick ? 1'b0 : block_r;
		if (tick) begin
			case (wmode)
				WM_CTC: begin
					// Only a real match clears the counter; a force never does.
					count_nxt = match_a ? 8'h00 : count_r + 8'h01;
				end
				WM_FAST_FF, WM_FAST_OCA: begin
					count_nxt = (count_r == top) ? 8'h00 : count_r + 8'h01;
				end
				WM_PC_FF, WM_PC_OCA: begin
					// Turn at top and at zero; the count only ever changes by one step.
					if (dir_r == DIR_UP) begin
						dir_nxt   = (count_r + 8'h01 >= top) ? DIR_DOWN : DIR_UP;
						count_nxt = (count_r >= top) ? count_r - 8'h01 : count_r + 8'h01;
					end else begin
						dir_nxt   = (count_r == 8'h01 || count_r == 8'h00) ? DIR_UP : DIR_DOWN;
						count_nxt = (count_r == 8'h00) ? 8'h01 : count_r - 8'h01;
					end
				end
				default: begin
					// Normal mode; reserved codes count the same way.
					count_nxt = count_r + 8'h01;
				end
			endcase
		end
		if (!is_pwm(wmode)) begin
			dir_nxt = DIR_UP;
		end
		// A software write to the counter overrides counting and arms the block.
		if (app[B_CNT]) begin
			count_nxt = app_val[B_CNT];
			block_nxt = 1'b1;
		end
		// Outside PWM modes a match or force steps the pin level; PWM shaping is left out.
		wave_a_nxt = wave_a_r;
		wave_b_nxt = wave_b_r;
		if (!is_pwm(wmode) && (match_a || frc_a)) begin
			wave_a_nxt = wave_step(mode_a, wave_a_r);
		end
		if (!is_pwm(wmode) && (match_b || frc_b)) begin
			wave_b_nxt = wave_step(mode_b, wave_b_r);
		end
		// Read mux; unmapped offsets answer zero.
		case (ADDR)
			A8TC_CTRL_A_OFS: rdata_nxt = ctla_r;
			A8TC_CTRL_B_OFS: rdata_nxt = ctlb_r & A8TC_CTLB_MASK;
			A8TC_COUNT_OFS:  rdata_nxt = count_r;
			A8TC_CMP_A_OFS:  rdata_nxt = cmpa_r;
			A8TC_CMP_B_OFS:  rdata_nxt = cmpb_r;
			A8TC_ASYNC_OFS:  rdata_nxt = asr_r | {3'h0, busy_r};
			default:         rdata_nxt = 8'h00;
		endcase
		if (!RSTROBE) begin
			rdata_nxt = 8'h00;
		end
	end

	// State registers only; all decisions are made above.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctla_r   <= A8TC_REG_RESET;
			ctlb_r   <= A8TC_REG_RESET;
			count_r  <= A8TC_REG_RESET;
			cmpa_r   <= A8TC_REG_RESET;
			cmpb_r   <= A8TC_REG_RESET;
			asr_r    <= A8TC_REG_RESET;
			busy_r   <= 5'h00;
			block_r  <= 1'b0;
			dir_r    <= DIR_UP;
			wave_a_r <= 1'b0;
			wave_b_r <= 1'b0;
			hit_a_r  <= 1'b0;
			hit_b_r  <= 1'b0;
			rdata_r  <= 8'h00;
			for (int i = 0; i < 5; i++) begin
				tmp_r[i] <= A8TC_REG_RESET;
			end
		end else begin
			ctla_r   <= ctla_nxt;
			ctlb_r   <= ctlb_nxt;
			count_r  <= count_nxt;
			cmpa_r   <= cmpa_nxt;
			cmpb_r   <= cmpb_nxt;
			asr_r    <= asr_nxt;
			busy_r   <= busy_nxt;
			block_r  <= block_nxt;
			dir_r    <= dir_nxt;
			wave_a_r <= wave_a_nxt;
			wave_b_r <= wave_b_nxt;
			hit_a_r  <= hit_a_nxt;
			hit_b_r  <= hit_b_nxt;
			rdata_r  <= rdata_nxt;
			tmp_r    <= tmp_nxt;
		end
	end

	// Pin muxing; the driver follows the direction bit, the level follows the mode field.
	assign COMPARE_PIN_A_OUT  = (mode_a != OM_OFF) ? wave_a_r : PORT_DATA_A;
	assign COMPARE_PIN_B_OUT  = (mode_b != OM_OFF) ? wave_b_r : PORT_DATA_B;
	assign COMPARE_PIN_A_OE_N = ~DIR_A;
	assign COMPARE_PIN_B_OE_N = ~DIR_B;
	assign COMPARE_A_MATCH    = hit_a_r;
	assign COMPARE_B_MATCH    = hit_b_r;
	assign RDATA              = rdata_r;
	// The crystal runs only in asynchronous mode without the external clock bit.
	assign XTAL_OSC_EN        = async_sel & ~asr_r[A8TC_EXT];
	assign EXT_CLK_BUF_EN     = async_sel & asr_r[A8TC_EXT];
	assign ALT_PIN_EN         = async_sel & asr_r[A8TC_ALT];

	// Checks sample on CLK and stay quiet while reset is held.
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);

	force_read_zero_a: assert property (RSTROBE && ADDR == A8TC_CTRL_B_OFS |=> RDATA[7:6] == 2'h0)
		else $error("force bits read nonzero");
	busy_set_a: assert property (WSTROBE && ADDR == A8TC_COUNT_OFS && async_sel |=> busy_r[B_CNT])
		else $error("count busy flag not set by async write");
	sync_write_a: assert property (WSTROBE && ADDR == A8TC_COUNT_OFS && !async_sel
		|=> count_r == $past(WDATA))
		else $error("sync counter write not taken");
	match_block_a: assert property (app[B_CNT] ##1 tick |=> !COMPARE_A_MATCH && !COMPARE_B_MATCH)
		else $error("match not blocked after counter write");
	clock_stop_a: assert property (ctlb_r[A8TC_CS_LO +: 3] == 3'h0 && !app[B_CNT]
		|-> !tick ##1 $stable(count_r))
		else $error("counter ticks while stopped");
	driver_dir_a: assert property (COMPARE_PIN_A_OE_N == !DIR_A && COMPARE_PIN_B_OE_N == !DIR_B)
		else $error("pin driver not following direction");
	override_b_a: assert property (mode_b != OM_OFF |-> COMPARE_PIN_B_OUT == wave_b_r)
		else $error("mode field does not take over pin");
	toggle_b_a: assert property (match_b && mode_b == OM_TOGGLE && !is_pwm(wmode)
		|=> wave_b_r != $past(wave_b_r))
		else $error("channel B did not toggle on match");
	force_pwm_a: assert property (app[B_CTB] && is_pwm(wmode) && !match_a && !match_b
		|=> $stable(wave_a_r) && $stable(wave_b_r))
		else $error("force acted in PWM mode");
	ctc_clear_a: assert property (match_a && wmode == WM_CTC && !app[B_CNT] |=> count_r == 8'h00)
		else $error("CTC did not clear on match");
	force_quiet_a: assert property (frc_a && !match_a |=> !COMPARE_A_MATCH)
		else $error("forced compare raised a match");
	osc_enable_a: assert property (XTAL_OSC_EN |-> !EXT_CLK_BUF_EN && !asr_r[A8TC_EXT])
		else $error("crystal runs with external clock bit set");
	// Pin levels, compare pulses, register writes, asynchronous transfers and counting, stated from the registers they follow.
	clear_b_a: assert property ((match_b || frc_b) && mode_b == OM_CLEAR && !is_pwm(wmode)
		|=> !wave_b_r)
		else $error("channel B not cleared on match");
	set_b_a: assert property ((match_b || frc_b) && mode_b == OM_SET && !is_pwm(wmode)
		|=> wave_b_r)
		else $error("channel B not set on match");
	force_toggle_a: assert property (frc_a && !match_a && mode_a == OM_TOGGLE
		|=> wave_a_r != $past(wave_a_r))
		else $error("force did not toggle channel A");
	port_pass_b_a: assert property (mode_b == OM_OFF |-> COMPARE_PIN_B_OUT == PORT_DATA_B)
		else $error("port value lost while channel B is off");
	match_pulse_a: assert property (tick && count_r == cmpa_r && !block_r |=> COMPARE_A_MATCH)
		else $error("compare A match pulse missing");
	stop_quiet_a: assert property (ctlb_r[A8TC_CS_LO +: 3] == 3'h0
		|=> !COMPARE_A_MATCH && !COMPARE_B_MATCH)
		else $error("match raised while stopped");
	sync_cmp_a: assert property (WSTROBE && ADDR == A8TC_CMP_B_OFS && !async_sel
		|=> cmpb_r == $past(WDATA))
		else $error("sync compare B write not taken");
	async_hold_a: assert property (WSTROBE && ADDR == A8TC_CMP_A_OFS && async_sel
		|=> busy_r[B_OCA] && cmpa_r == $past(cmpa_r))
		else $error("async compare A write bypassed temporary storage");
	busy_clear_a: assert property (async_sel && busy_r[B_OCB] && clk_bus.src_tick && !WSTROBE
		|=> !busy_r[B_OCB] && cmpb_r == $past(tmp_r[B_OCB]))
		else $error("compare B transfer did not complete");
	count_step_a: assert property (tick && wmode == WM_NORMAL && !app[B_CNT]
		|=> count_r == $past(count_r) + 8'h01)
		else $error("normal mode did not count up");

endmodule : a8tc_top

// ===== verilog/a8tc_pkg.sv
// Package of the 8-bit asynchronous timer control block: offsets, fields, reset values, modes.
// Assumes a byte-wide register port with 8-bit addresses and a single system clock.
package a8tc_pkg;

	// Register offsets on the byte-wide register port.
	localparam logic [7:0] A8TC_CTRL_A_OFS = 8'hb0;
	localparam logic [7:0] A8TC_CTRL_B_OFS = 8'hb1;
	localparam logic [7:0] A8TC_COUNT_OFS  = 8'hb2;
	localparam logic [7:0] A8TC_CMP_A_OFS  = 8'hb3;
	localparam logic [7:0] A8TC_CMP_B_OFS  = 8'hb4;
	localparam logic [7:0] A8TC_ASYNC_OFS  = 8'hb6;

	// Field positions in timer_control_a.
	localparam int A8TC_COMA_LO = 6;
	localparam int A8TC_COMB_LO = 4;
	localparam int A8TC_WGM_LO  = 0;
	// Field positions in timer_control_b.
	localparam int A8TC_FOCA    = 7;
	localparam int A8TC_FOCB    = 6;
	localparam int A8TC_WGM2    = 3;
	localparam int A8TC_CS_LO   = 0;
	// Field positions in async_clock_status.
	localparam int A8TC_ALT     = 7;
	localparam int A8TC_EXT     = 6;
	localparam int A8TC_ASEL    = 5;
	localparam int A8TC_BUSY_LO = 0;

	// Implemented bits; all other bits read as zero, except the busy flags in async_clock_status.
	localparam logic [7:0] A8TC_CTLA_MASK  = 8'hf3;
	localparam logic [7:0] A8TC_CTLB_MASK  = 8'h0f;
	localparam logic [7:0] A8TC_ASYNC_MASK = 8'he0;

	// Reset value of every register and the fixed top.
	localparam logic [7:0] A8TC_REG_RESET = 8'h00;
	localparam logic [7:0] A8TC_TOP_MAX   = 8'hff;

	// Prescaler masks for divisions 8, 32, 64, 128, 256 and 1024.
	localparam logic [9:0] A8TC_DIV8_MASK    = 10'h007;
	localparam logic [9:0] A8TC_DIV32_MASK   = 10'h01f;
	localparam logic [9:0] A8TC_DIV64_MASK   = 10'h03f;
	localparam logic [9:0] A8TC_DIV128_MASK  = 10'h07f;
	localparam logic [9:0] A8TC_DIV256_MASK  = 10'h0ff;
	localparam logic [9:0] A8TC_DIV1024_MASK = 10'h3ff;

	typedef enum logic [2:0] {
		WM_NORMAL   = 3'h0,
		WM_PC_FF    = 3'h1,
		WM_CTC      = 3'h2,
		WM_FAST_FF  = 3'h3,
		WM_RES4     = 3'h4,
		WM_PC_OCA   = 3'h5,
		WM_RES6     = 3'h6,
		WM_FAST_OCA = 3'h7
	} a8tc_wave_mode_t;

	typedef enum logic [1:0] {
		OM_OFF    = 2'h0,
		OM_TOGGLE = 2'h1,
		OM_CLEAR  = 2'h2,
		OM_SET    = 2'h3
	} a8tc_out_mode_t;

	// Counting direction; only phase-correct modes ever leave the up state.
	typedef enum logic {
		DIR_UP   = 1'b0,
		DIR_DOWN = 1'b1
	} a8tc_dir_t;

endpackage : a8tc_pkg

// ===== verilog/a8tc_clk_if.sv
// Interface carrying clock configuration and tick strobes between the core and the prescaler.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface a8tc_clk_if;
	logic       async_sel;
	logic       ext_clk;
	logic       alt_clk;
	logic [2:0] clock_select;
	logic       src_tick;
	logic       cnt_tick;

	modport pre  (input async_sel, ext_clk, alt_clk, clock_select, output src_tick, cnt_tick);
	modport core (output async_sel, ext_clk, alt_clk, clock_select, input src_tick, cnt_tick);
endinterface : a8tc_clk_if

// ===== verilog/a8tc_prescaler.sv
// Timer source selection and prescaler: turns the chosen clock source into count ticks.
// Assumes the oscillator and alternate pins are far slower than the system clock.
`timescale 1ns/1ps
module a8tc_prescaler
	import a8tc_pkg::*;
#(
	parameter int PRESCALE_W = 10
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic osc_pin,
	input wire logic alt_pin,
	a8tc_clk_if.pre  clk_if
);

	generate
		if (PRESCALE_W < 10) begin : g_bad_width
			$error("a8tc_prescaler: PRESCALE_W must be at least 10");
		end
	endgenerate

	logic [1:0]            osc_sh_r, osc_sh_nxt;
	logic [1:0]            alt_sh_r, alt_sh_nxt;
	logic                  osc_prev_r, osc_prev_nxt;
	logic                  alt_prev_r, alt_prev_nxt;
	logic [PRESCALE_W-1:0] pre_r, pre_nxt;
	logic [9:0]            mask;
	logic                  osc_rise;
	logic                  alt_rise;

	// Division mask for a clock select code; zero means every source tick.
	function automatic logic [9:0] div_mask(input logic [2:0] cs);
		case (cs)
			3'h2:    div_mask = A8TC_DIV8_MASK;
			3'h3:    div_mask = A8TC_DIV32_MASK;
			3'h4:    div_mask = A8TC_DIV64_MASK;
			3'h5:    div_mask = A8TC_DIV128_MASK;
			3'h6:    div_mask = A8TC_DIV256_MASK;
			3'h7:    div_mask = A8TC_DIV1024_MASK;
			default: div_mask = 10'h000;
		endcase
	endfunction : div_mask

	// Edges are taken from the second stage only, so the first stage never feeds logic.
	// The pin's data direction is never looked at, so an output pin still clocks the counter.
	always_comb begin
		osc_sh_nxt   = {osc_sh_r[0], osc_pin};
		alt_sh_nxt   = {alt_sh_r[0], alt_pin};
		osc_prev_nxt = osc_sh_r[1];
		alt_prev_nxt = alt_sh_r[1];
		osc_rise     = osc_sh_r[1] & ~osc_prev_r;
		alt_rise     = alt_sh_r[1] & ~alt_prev_r;
		// I/O clock when not asynchronous, else the alternate pin or the oscillator pin.
		if (!clk_if.async_sel) begin
			clk_if.src_tick = 1'b1;
		end else if (clk_if.alt_clk) begin
			clk_if.src_tick = alt_rise;
		end else begin
			clk_if.src_tick = osc_rise;
		end
		mask    = div_mask(clk_if.clock_select);
		pre_nxt = clk_if.src_tick ? pre_r + 1'b1 : pre_r;
		// Stop, undivided or one tick each time the masked prescaler bits are all ones.
		clk_if.cnt_tick = clk_if.src_tick && (clk_if.clock_select != 3'h0) &&
			((pre_r[9:0] & mask) == mask);
	end

	// Registers of the synchronisers and the prescaler.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_sh_r   <= 2'h0;
			alt_sh_r   <= 2'h0;
			osc_prev_r <= 1'b0;
			alt_prev_r <= 1'b0;
			pre_r      <= '0;
		end else begin
			osc_sh_r   <= osc_sh_nxt;
			alt_sh_r   <= alt_sh_nxt;
			osc_prev_r <= osc_prev_nxt;
			alt_prev_r <= alt_prev_nxt;
			pre_r      <= pre_nxt;
		end
	end

endmodule : a8tc_prescaler

// ===== verification/a8tc_tb_top.sv
// Self-checking bench of the timer control block: registers, pins, forced and real compares, async clocking.
// Assumes a8tc_top with its one-cycle register port; the bench drives every port itself.
`timescale 1ns/1ps
module async_8bit_timer_control_tb_top
	import a8tc_pkg::*;
;
	typedef struct packed { logic [7:0] a; logic [7:0] d; logic [7:0] q; } a8tc_reg_row_t;
	typedef struct packed { logic [7:0] ca; logic [7:0] cb; logic pa; logic pb; } a8tc_frc_row_t;

	logic          clk, rst_n, wstrobe, rstrobe, osc_pin, alt_pin, dir_a, dir_b, pd_a, pd_b, osc_run, alt_run;
	logic [7:0]    addr, wdata, rdata, rd;
	logic          pin_a, oe_a_n, pin_b, oe_b_n, match_a, match_b, xtal_en, ext_en, alt_en, pexp;
	int            n_mismatch, checks_done, cyc, i;
	int            divs [6] = '{8, 32, 64, 128, 256, 1024};
	logic [7:0]    ofs [6] = '{A8TC_CTRL_A_OFS, A8TC_CTRL_B_OFS, A8TC_COUNT_OFS, A8TC_CMP_A_OFS,
	                           A8TC_CMP_B_OFS, A8TC_ASYNC_OFS};
	a8tc_reg_row_t regs [9] = '{
		'{A8TC_CTRL_A_OFS, 8'hff, 8'hf3}, '{A8TC_CTRL_A_OFS, 8'h00, 8'h00}, '{A8TC_CTRL_B_OFS, 8'hf0, 8'h00},
		'{A8TC_COUNT_OFS, 8'h77, 8'h77}, '{A8TC_CMP_A_OFS, 8'h5a, 8'h5a}, '{A8TC_CMP_B_OFS, 8'ha5, 8'ha5},
		'{A8TC_ASYNC_OFS, 8'h1f, 8'h00}, '{8'hb5, 8'h33, 8'h00}, '{8'hb7, 8'hff, 8'h00}};
	// Pin expectations assume port data A high and B low; row five selects a PWM mode, row six CTC.
	a8tc_frc_row_t frcs [7] = '{
		'{8'hf0, 8'hc0, 1'b1, 1'b1}, '{8'ha0, 8'hc0, 1'b0, 1'b0}, '{8'h50, 8'hc0, 1'b1, 1'b1},
		'{8'h50, 8'h40, 1'b1, 1'b0}, '{8'h51, 8'hc0, 1'b1, 1'b0}, '{8'h52, 8'h80, 1'b0, 1'b0},
		'{8'h00, 8'h00, 1'b1, 1'b0}};

	a8tc_top #(.PRESCALE_W(10)) dut_u (
		.CLK(clk), .RSTN(rst_n), .ADDR(addr), .WDATA(wdata), .WSTROBE(wstrobe), .RSTROBE(rstrobe),
		.RDATA(rdata), .TIMER_OSC_PIN_ONE(osc_pin), .ALTERNATE_CLOCK_PIN(alt_pin), .DIR_A(dir_a),
		.DIR_B(dir_b), .PORT_DATA_A(pd_a), .PORT_DATA_B(pd_b), .COMPARE_PIN_A_OUT(pin_a),
		.COMPARE_PIN_A_OE_N(oe_a_n), .COMPARE_PIN_B_OUT(pin_b), .COMPARE_PIN_B_OE_N(oe_b_n),
		.COMPARE_A_MATCH(match_a), .COMPARE_B_MATCH(match_b), .XTAL_OSC_EN(xtal_en),
		.EXT_CLK_BUF_EN(ext_en), .ALT_PIN_EN(alt_en));

	// 200 MHz system clock.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Slow stand-in for the oscillator and alternate pins; it stands still until asked to run.
	initial begin
		forever begin
			repeat (10) @(posedge clk);
			if (osc_run) begin
				osc_pin <= ~osc_pin;
			end
			// The alternate pin runs on its own, so a transfer that waits for it proves the source choice.
			if (alt_run) begin
				alt_pin <= ~alt_pin;
			end
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop();
		if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : report_and_stop

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr    <= a;
		wdata   <= d;
		wstrobe <= 1'b1;
		@(posedge clk);
		wstrobe <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so they are sampled just after that edge.
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		addr    <= a;
		rstrobe <= 1'b1;
		@(posedge clk);
		rstrobe <= 1'b0;
		#1 rd = rdata;
	endtask : rd_reg

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// Polls the status register until the given busy flag drops, under a bounded count.
	task automatic wait_idle(input int b);
		for (int k = 0; k < 80; k++) begin
			rd_reg(A8TC_ASYNC_OFS);
			if (rd[b] === 1'b0) return;
		end
		n_mismatch++;
		$display("unexpected at %0t: busy flag never cleared", $time);
		report_and_stop();
	endtask : wait_idle

	// Waits for a compare A pulse under a bounded count; cyc keeps the number of cycles waited.
	task automatic wait_match();
		for (cyc = 0; match_a !== 1'b1 && cyc < 300; cyc++) begin
			tick(1);
		end
		if (cyc >= 300) begin
			n_mismatch++;
			$display("unexpected at %0t: compare match never seen", $time);
			report_and_stop();
		end
	endtask : wait_match

	// Main sequence: reset, table rows, then the hand-written compare, prescale and async cases.
	initial begin
		{rst_n, wstrobe, rstrobe, osc_pin, osc_run, alt_run, dir_b, pd_b, addr, wdata} = '0;
		{alt_pin, dir_a, pd_a} = 3'b111;
		n_mismatch = 0;
		checks_done = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 6; i++) begin
			rd_reg(ofs[i]);
			check(rd, A8TC_REG_RESET);
		end
		check({pin_a, pin_b, oe_a_n, oe_b_n}, 8'h09);
		check({xtal_en, ext_en, alt_en, match_a, match_b}, 8'h00);
		for (i = 0; i < 9; i++) begin
			wr(regs[i].a, regs[i].d);
			rd_reg(regs[i].a);
			check(rd, regs[i].q);
		end
		for (i = 0; i < 7; i++) begin
			wr(A8TC_CTRL_A_OFS, frcs[i].ca);
			wr(A8TC_CTRL_B_OFS, frcs[i].cb);
			tick(2);
			check(pin_a, frcs[i].pa);
			check(pin_b, frcs[i].pb);
			check({match_a, match_b}, 8'h00);
		end
		// A PWM mode is selected with the force bits left at zero.
		wr(A8TC_CTRL_A_OFS, 8'h51);
		wr(A8TC_CTRL_B_OFS, 8'h00);
		@(posedge clk);
		dir_a <= 1'b0;
		dir_b <= 1'b1;
		tick(1);
		check({oe_a_n, oe_b_n}, 8'h02);
		// Real matches with both channels in toggle mode, counting every system clock.
		wr(A8TC_CTRL_A_OFS, 8'h50);
		wr(A8TC_CMP_A_OFS, 8'h20);
		wr(A8TC_COUNT_OFS, 8'h00);
		pexp = ~pin_a;
		wr(A8TC_CTRL_B_OFS, 8'h01);
		wait_match();
		check(pin_a, pexp);
		tick(1);
		check(match_a, 8'h00);
		// Writing the compare value into the counter must hide the match until the count wraps.
		wr(A8TC_COUNT_OFS, 8'h20);
		wait_match();
		check(8'(cyc >= 250 && cyc <= 262), 8'h01);
		for (i = 0; i < 6; i++) begin
			wr(A8TC_CTRL_B_OFS, 8'h00);
			wr(A8TC_COUNT_OFS, 8'h00);
			wr(A8TC_CTRL_B_OFS, 8'(i + 2));
			repeat (4 * divs[i]) @(posedge clk);
			wr(A8TC_CTRL_B_OFS, 8'h00);
			rd_reg(A8TC_COUNT_OFS);
			check(8'(rd >= 3 && rd <= 5), 8'h01);
		end
		cyc = rd;
		tick(20);
		rd_reg(A8TC_COUNT_OFS);
		check(rd, 8'(cyc));
		// One clock bit changes per write, and the external bit is set before async mode.
		wr(A8TC_ASYNC_OFS, 8'h40);
		tick(1);
		check(ext_en, 8'h00);
		wr(A8TC_ASYNC_OFS, 8'h60);
		tick(1);
		check({xtal_en, ext_en}, 8'h01);
		rd_reg(A8TC_ASYNC_OFS);
		check(rd, 8'h60);
		wr(A8TC_CMP_B_OFS, 8'h99);
		rd_reg(A8TC_ASYNC_OFS);
		check(rd, 8'h64);
		osc_run <= 1'b1;
		wait_idle(2);
		check(rd, 8'h60);
		rd_reg(A8TC_CMP_B_OFS);
		check(rd, 8'h99);
		wr(A8TC_ASYNC_OFS, 8'h20);
		tick(1);
		check({xtal_en, ext_en}, 8'h02);
		wr(A8TC_ASYNC_OFS, 8'ha0);
		tick(1);
		check(alt_en, 8'h01);
		wr(A8TC_CMP_A_OFS, 8'h11);
		tick(40);
		rd_reg(A8TC_ASYNC_OFS);
		check(rd, 8'ha8);
		alt_run <= 1'b1;
		wait_idle(3);
		rd_reg(A8TC_CMP_A_OFS);
		check(rd, 8'h11);
		report_and_stop();
	end
endmodule : async_8bit_timer_control_tb_top
